// file: rtl/rlc_pkg.sv
// Constants and types shared by the lane control register bank
`default_nettype none
package rlc_pkg;
   // Register map, byte offsets on the serial management bus
   localparam logic [7:0] RLC_OFF_GAP_LOW   = 8'h37;
   localparam logic [7:0] RLC_OFF_SD_L6     = 8'h38;
   localparam logic [7:0] RLC_OFF_IDLE_L6   = 8'h39;
   localparam logic [7:0] RLC_OFF_EQ_L6     = 8'h3A;
   localparam logic [7:0] RLC_OFF_SWING_L6  = 8'h3B;
   localparam logic [7:0] RLC_OFF_DEEM_L6   = 8'h3C;
   localparam logic [7:0] RLC_OFF_THR_L6    = 8'h3D;
   localparam logic [7:0] RLC_OFF_GAP_HIGH  = 8'h3E;
   localparam logic [7:0] RLC_OFF_SD_L7     = 8'h3F;
   localparam int         RLC_NUM_REGS      = 9;

   // Reset values
   localparam logic [7:0] RLC_RST_ZERO      = 8'h00;
   localparam logic [7:0] RLC_RST_EQ        = 8'h2F;
   localparam logic [7:0] RLC_RST_SWING     = 8'hAD;
   localparam logic [7:0] RLC_RST_DEEM      = 8'h02;

   // Field positions
   localparam int RLC_BIT_SD_FORCE_OFF      = 2;
   localparam int RLC_BIT_SD_FORCE_ON       = 1;
   localparam int RLC_BIT_IDLE_MANUAL       = 5;
   localparam int RLC_BIT_IDLE_MUTE         = 4;
   localparam int RLC_PROBE_HI              = 3;
   localparam int RLC_PROBE_LO              = 2;
   localparam int RLC_BIT_SHORT_PROT        = 7;
   localparam int RLC_BIT_RATE_SEL          = 6;
   localparam int RLC_SWING_HI              = 2;
   localparam int RLC_BIT_RX_FOUND          = 7;
   localparam int RLC_RATE_DET_HI           = 6;
   localparam int RLC_RATE_DET_LO           = 5;
   localparam int RLC_DEEM_KEEP_HI          = 4;
   localparam int RLC_DEEM_HI               = 2;
   localparam int RLC_THR_ASSERT_HI         = 3;
   localparam int RLC_THR_ASSERT_LO         = 2;
   localparam int RLC_THR_DEASSERT_HI       = 1;

   // Receiver-detect control codes
   localparam logic [1:0] RLC_PROBE_HIZ     = 2'h0;
   localparam logic [1:0] RLC_PROBE_LIMITED = 2'h1;
   localparam logic [1:0] RLC_PROBE_ENDLESS = 2'h2;
   localparam logic [1:0] RLC_PROBE_FIXED   = 2'h3;

   // Receiver-detect timing
   localparam int unsigned RLC_CLK_MHZ        = 250;
   localparam int unsigned RLC_TEST_PERIOD_MS = 12;
   localparam int unsigned RLC_TEST_WINDOW_MS = 600;
   localparam int unsigned RLC_TEST_PERIOD_CYC = RLC_TEST_PERIOD_MS * 1000 * RLC_CLK_MHZ;
   localparam logic [7:0]  RLC_TEST_ATTEMPTS  =
      8'(RLC_TEST_WINDOW_MS / RLC_TEST_PERIOD_MS);

   // Bus slave address, arbitrary value
   localparam logic [6:0] RLC_DEV_ADDR       = 7'h18;

   typedef enum logic [3:0] {
      RLC_SL_IDLE      = 4'h0,
      RLC_SL_ADDR      = 4'h1,
      RLC_SL_ADDR_ACK  = 4'h3,
      RLC_SL_REG       = 4'h2,
      RLC_SL_REG_ACK   = 4'h6,
      RLC_SL_WDATA     = 4'h7,
      RLC_SL_WDATA_ACK = 4'h5,
      RLC_SL_RDATA     = 4'h4,
      RLC_SL_MACK      = 4'hC
   } rlc_slave_state_t;

   typedef enum logic [2:0] {
      RLC_RD_OFF     = 3'h0,
      RLC_RD_SEARCH  = 3'h1,
      RLC_RD_FOUND   = 3'h3,
      RLC_RD_STOPPED = 3'h2,
      RLC_RD_FIXED   = 3'h6
   } rlc_probe_state_t;

   function automatic logic [7:0] rlc_reset_val(input int idx);
      case (idx)
         3:       rlc_reset_val = RLC_RST_EQ;
         4:       rlc_reset_val = RLC_RST_SWING;
         5:       rlc_reset_val = RLC_RST_DEEM;
         default: rlc_reset_val = RLC_RST_ZERO;
      endcase
   endfunction
endpackage
`default_nettype wire

// file: rtl/rlc_receiver_detect_control_seq.sv
// Receiver-detect sequencer for one lane
`default_nettype none
module rlc_probe_seq
   import rlc_pkg::*;
#(
   parameter int unsigned PERIOD_CYC = rlc_pkg::RLC_TEST_PERIOD_CYC
) (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic [1:0] mode_i,
   input  wire logic       present_i,
   output logic            term_50_o,
   output logic            test_o,
   output logic            found_o
);
   rlc_probe_state_t state_q;
   logic [1:0]       mode_q;
   logic [31:0]      timer_q;
   logic [7:0]       tries_q;
   logic             restart;

   assign restart = (mode_i != mode_q);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         mode_q <= RLC_PROBE_HIZ;
      end else begin
         mode_q <= mode_i;
      end
   end

   // Test strobe and attempt count
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         timer_q <= 32'h0;
         tries_q <= 8'h0;
         test_o  <= 1'b0;
      end else if (restart || state_q != RLC_RD_SEARCH) begin
         timer_q <= 32'h0;
         tries_q <= 8'h0;
         test_o  <= 1'b0;
      end else if (timer_q == PERIOD_CYC - 32'd1) begin
         timer_q <= 32'h0;
         tries_q <= tries_q + 8'h1;
         test_o  <= 1'b1;
      end else begin
         timer_q <= timer_q + 32'h1;
         test_o  <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q   <= RLC_RD_OFF;
         term_50_o <= 1'b0;
         found_o   <= 1'b0;
      end else if (restart) begin
         found_o <= 1'b0;
         case (mode_i)
            RLC_PROBE_HIZ: begin
               state_q   <= RLC_RD_OFF;
               term_50_o <= 1'b0;
            end
            RLC_PROBE_FIXED: begin
               state_q   <= RLC_RD_FIXED;
               term_50_o <= 1'b1;
            end
            default: begin
               state_q   <= RLC_RD_SEARCH;
               term_50_o <= 1'b0;
            end
         endcase
      end else begin
         case (state_q)
            RLC_RD_SEARCH: begin
               // Result is judged in the same cycle as each test strobe
               if (test_o && present_i) begin
                  state_q   <= RLC_RD_FOUND;
                  term_50_o <= 1'b1;
                  found_o   <= 1'b1;
               end else if (test_o && mode_q == RLC_PROBE_LIMITED &&
                            tries_q == RLC_TEST_ATTEMPTS) begin
                  state_q <= RLC_RD_STOPPED;
               end
            end
            default: begin
               state_q <= state_q;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// file: rtl/rlc_lane_regs.sv
// Lane six control bank and lane seven signal-detect force behind a serial management slave
// Functional notes
// - Force-off bit holds signal detect low
// - Force-on bit holds signal detect high
// - Manual idle bit selects force-mute control
// - Manual mute bit one mutes output
// - Detect code 00 keeps input high impedance
// - Code 01 tests every 12 ms, 50 times
// - Code 10 tests every 12 ms endlessly
// - Auto modes terminate 50 ohm after detection
// - Equalizer level eight bits, reset 0x2F
// - Swing bit 7 enables short protection
// - Bit 6 selects older rate class
// - Swing field three bits, default 101
// - Status bit 7 shows receiver found
// - Bits 6:5 report detected rate class
// - De-emphasis field three bits, default 010
// - Assert threshold bits 3:2, default 00
// - Deassert threshold bits 1:0, default 00
`default_nettype none
module rlc_lane_regs
   import rlc_pkg::*;
#(
   parameter int unsigned TEST_PERIOD_CYC = rlc_pkg::RLC_TEST_PERIOD_CYC
) (
   input  wire logic       CLK_SYS_I,
   input  wire logic       RST_I,
   input  wire logic       SMB_SCL_I,
   input  wire logic       SMB_SDA_I,
   output logic            SMB_SDA_O,
   output logic            SMB_SDA_OE_O,
   input  wire logic       RAW_SIGNAL_DETECT_I,
   input  wire logic       RAW_SIGNAL_DETECT_L7_I,
   input  wire logic       RECEIVER_PRESENT_I,
   input  wire logic [1:0] RATE_CLASS_DET_I,
   output logic            SIGNAL_DETECT_O,
   output logic            SIGNAL_DETECT_L7_O,
   output logic            OUTPUT_MUTE_O,
   output logic            TERM_50_O,
   output logic            RX_TEST_O,
   output logic            RECEIVER_FOUND_O,
   output logic [7:0]      EQUALIZER_LEVEL_O,
   output logic            SHORT_PROT_EN_O,
   output logic            RATE_CLASS_LOW_O,
   output logic [2:0]      OUTPUT_SWING_LEVEL_O,
   output logic [2:0]      DEEMPHASIS_LEVEL_O,
   output logic [1:0]      IDLE_ASSERT_TH_O,
   output logic [1:0]      IDLE_DEASSERT_TH_O
);
   logic [2:0]       scl_sync_q;
   logic [2:0]       sda_sync_q;
   logic [1:0]       sd_sync_q;
   logic [1:0]       sd7_sync_q;
   logic [1:0]       present_sync_q;
   logic [1:0]       rate_s1_q;
   logic [1:0]       rate_s2_q;
   logic             scl_rise;
   logic             scl_fall;
   logic             bus_start;
   logic             bus_stop;
   rlc_slave_state_t sl_q;
   logic [3:0]       bit_cnt_q;
   logic [7:0]       shift_q;
   logic [7:0]       ptr_q;
   logic             rw_q;
   logic             oe_q;
   logic             wr_stb_q;
   logic [7:0]       wr_addr_q;
   logic [7:0]       wr_data_q;
   logic [7:0]       regs_q [RLC_NUM_REGS];
   logic [7:0]       rd_val;
   logic             found;
   logic             sd_lane6;

   function automatic logic is_mapped(input logic [7:0] addr);
      is_mapped = (addr >= RLC_OFF_GAP_LOW) && (addr <= RLC_OFF_SD_L7);
   endfunction

   function automatic logic [3:0] reg_index(input logic [7:0] addr);
      logic [7:0] diff;
      diff      = addr - RLC_OFF_GAP_LOW;
      reg_index = diff[3:0];
   endfunction

   // Pins and analog flags come from outside the clock domain
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         scl_sync_q     <= 3'h7;
         sda_sync_q     <= 3'h7;
         sd_sync_q      <= 2'h0;
         sd7_sync_q     <= 2'h0;
         present_sync_q <= 2'h0;
         rate_s1_q      <= 2'h0;
         rate_s2_q      <= 2'h0;
      end else begin
         scl_sync_q     <= {scl_sync_q[1:0], SMB_SCL_I};
         sda_sync_q     <= {sda_sync_q[1:0], SMB_SDA_I};
         sd_sync_q      <= {sd_sync_q[0], RAW_SIGNAL_DETECT_I};
         sd7_sync_q     <= {sd7_sync_q[0], RAW_SIGNAL_DETECT_L7_I};
         present_sync_q <= {present_sync_q[0], RECEIVER_PRESENT_I};
         rate_s1_q      <= RATE_CLASS_DET_I;
         rate_s2_q      <= rate_s1_q;
      end
   end

   // Edges only look at the second and third stages
   assign scl_rise  = scl_sync_q[1] & ~scl_sync_q[2];
   assign scl_fall  = ~scl_sync_q[1] & scl_sync_q[2];
   assign bus_start = scl_sync_q[1] & scl_sync_q[2] & ~sda_sync_q[1] & sda_sync_q[2];
   assign bus_stop  = scl_sync_q[1] & scl_sync_q[2] & sda_sync_q[1] & ~sda_sync_q[2];

   // Read view; bits 7:5 of the de-emphasis register are live status
   always_comb begin
      rd_val = 8'h00;
      if (is_mapped(ptr_q)) begin
         rd_val = regs_q[reg_index(ptr_q)];
         if (ptr_q == RLC_OFF_DEEM_L6) begin
            rd_val = {found, rate_s2_q,
                      regs_q[reg_index(RLC_OFF_DEEM_L6)][RLC_DEEM_KEEP_HI:0]};
         end
      end
   end

   // Serial slave; SDA is only ever pulled low, so the data level stays zero
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         SMB_SDA_O <= 1'b0;
      end else begin
         SMB_SDA_O <= 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         sl_q      <= RLC_SL_IDLE;
         bit_cnt_q <= 4'h0;
         shift_q   <= 8'h00;
         ptr_q     <= 8'h00;
         rw_q      <= 1'b0;
         oe_q      <= 1'b0;
         wr_stb_q  <= 1'b0;
         wr_addr_q <= 8'h00;
         wr_data_q <= 8'h00;
      end else begin
         wr_stb_q <= 1'b0;
         if (bus_stop) begin
            sl_q <= RLC_SL_IDLE;
            oe_q <= 1'b0;
         end else if (bus_start) begin
            sl_q      <= RLC_SL_ADDR;
            bit_cnt_q <= 4'h0;
            oe_q      <= 1'b0;
         end else if (scl_rise) begin
            case (sl_q)
               RLC_SL_ADDR, RLC_SL_REG, RLC_SL_WDATA: begin
                  shift_q   <= {shift_q[6:0], sda_sync_q[1]};
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end
               RLC_SL_MACK: begin
                  rw_q <= ~sda_sync_q[1];
               end
               default: begin
                  shift_q <= shift_q;
               end
            endcase
         end else if (scl_fall) begin
            case (sl_q)
               RLC_SL_ADDR: begin
                  if (bit_cnt_q == 4'h8) begin
                     if (shift_q[7:1] == RLC_DEV_ADDR) begin
                        rw_q <= shift_q[0];
                        oe_q <= 1'b1;
                        sl_q <= RLC_SL_ADDR_ACK;
                     end else begin
                        sl_q <= RLC_SL_IDLE;
                     end
                  end
               end
               RLC_SL_ADDR_ACK: begin
                  bit_cnt_q <= 4'h0;
                  if (rw_q) begin
                     shift_q <= {rd_val[6:0], 1'b0};
                     oe_q    <= ~rd_val[7];
                     sl_q    <= RLC_SL_RDATA;
                  end else begin
                     oe_q <= 1'b0;
                     sl_q <= RLC_SL_REG;
                  end
               end
               RLC_SL_REG: begin
                  if (bit_cnt_q == 4'h8) begin
                     ptr_q <= shift_q;
                     oe_q  <= 1'b1;
                     sl_q  <= RLC_SL_REG_ACK;
                  end
               end
               RLC_SL_REG_ACK, RLC_SL_WDATA_ACK: begin
                  bit_cnt_q <= 4'h0;
                  oe_q      <= 1'b0;
                  sl_q      <= RLC_SL_WDATA;
               end
               RLC_SL_WDATA: begin
                  if (bit_cnt_q == 4'h8) begin
                     wr_stb_q  <= 1'b1;
                     wr_addr_q <= ptr_q;
                     wr_data_q <= shift_q;
                     ptr_q     <= ptr_q + 8'h01;
                     oe_q      <= 1'b1;
                     sl_q      <= RLC_SL_WDATA_ACK;
                  end
               end
               RLC_SL_RDATA: begin
                  if (bit_cnt_q == 4'h7) begin
                     oe_q  <= 1'b0;
                     ptr_q <= ptr_q + 8'h01;
                     sl_q  <= RLC_SL_MACK;
                  end else begin
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                     oe_q      <= ~shift_q[7];
                     shift_q   <= {shift_q[6:0], 1'b0};
                  end
               end
               RLC_SL_MACK: begin
                  // Master acknowledge asks for the next byte, a NACK ends the read
                  bit_cnt_q <= 4'h0;
                  if (rw_q) begin
                     shift_q <= {rd_val[6:0], 1'b0};
                     oe_q    <= ~rd_val[7];
                     sl_q    <= RLC_SL_RDATA;
                  end else begin
                     sl_q <= RLC_SL_IDLE;
                  end
               end
               default: begin
                  sl_q <= RLC_SL_IDLE;
               end
            endcase
         end
      end
   end

   assign SMB_SDA_OE_O = oe_q;

   // Register storage; unmapped offsets swallow writes
   for (genvar gi = 0; gi < RLC_NUM_REGS; gi++) begin : g_reg
      always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
         if (RST_I) begin
            regs_q[gi] <= rlc_reset_val(gi);
         end else if (wr_stb_q && is_mapped(wr_addr_q) &&
                      reg_index(wr_addr_q) == 4'(gi)) begin
            regs_q[gi] <= wr_data_q;
         end
      end
   end

   rlc_probe_seq #(
      .PERIOD_CYC (TEST_PERIOD_CYC)
   ) u_probe (
      .clk_i     (CLK_SYS_I),
      .rst_i     (RST_I),
      .mode_i    (regs_q[reg_index(RLC_OFF_IDLE_L6)][RLC_PROBE_HI:RLC_PROBE_LO]),
      .present_i (present_sync_q[1]),
      .term_50_o (TERM_50_O),
      .test_o    (RX_TEST_O),
      .found_o   (found)
   );

   assign RECEIVER_FOUND_O = found;

   // Force-off wins over force-on when both are set
   assign sd_lane6 = regs_q[reg_index(RLC_OFF_SD_L6)][RLC_BIT_SD_FORCE_OFF] ? 1'b0 :
                     regs_q[reg_index(RLC_OFF_SD_L6)][RLC_BIT_SD_FORCE_ON]  ? 1'b1 :
                     sd_sync_q[1];

   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         SIGNAL_DETECT_O    <= 1'b0;
         SIGNAL_DETECT_L7_O <= 1'b0;
      end else begin
         SIGNAL_DETECT_O    <= sd_lane6;
         if (regs_q[reg_index(RLC_OFF_SD_L7)][RLC_BIT_SD_FORCE_OFF]) begin
            SIGNAL_DETECT_L7_O <= 1'b0;
         end else if (regs_q[reg_index(RLC_OFF_SD_L7)][RLC_BIT_SD_FORCE_ON]) begin
            SIGNAL_DETECT_L7_O <= 1'b1;
         end else begin
            SIGNAL_DETECT_L7_O <= sd7_sync_q[1];
         end
      end
   end

   // Automatic idle mutes while no signal is detected
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I) begin
         OUTPUT_MUTE_O <= 1'b1;
      end else if (regs_q[reg_index(RLC_OFF_IDLE_L6)][RLC_BIT_IDLE_MANUAL]) begin
         OUTPUT_MUTE_O <= regs_q[reg_index(RLC_OFF_IDLE_L6)][RLC_BIT_IDLE_MUTE];
      end else begin
         OUTPUT_MUTE_O <= ~sd_lane6;
      end
   end

   // Analog settings come straight off the stored bytes; they override the pins
   assign EQUALIZER_LEVEL_O    = regs_q[reg_index(RLC_OFF_EQ_L6)];
   assign SHORT_PROT_EN_O      = regs_q[reg_index(RLC_OFF_SWING_L6)][RLC_BIT_SHORT_PROT];
   assign RATE_CLASS_LOW_O     = regs_q[reg_index(RLC_OFF_SWING_L6)][RLC_BIT_RATE_SEL];
   assign OUTPUT_SWING_LEVEL_O = regs_q[reg_index(RLC_OFF_SWING_L6)][RLC_SWING_HI:0];
   assign DEEMPHASIS_LEVEL_O   = regs_q[reg_index(RLC_OFF_DEEM_L6)][RLC_DEEM_HI:0];
   assign IDLE_ASSERT_TH_O     =
      regs_q[reg_index(RLC_OFF_THR_L6)][RLC_THR_ASSERT_HI:RLC_THR_ASSERT_LO];
   assign IDLE_DEASSERT_TH_O   =
      regs_q[reg_index(RLC_OFF_THR_L6)][RLC_THR_DEASSERT_HI:0];
endmodule
`default_nettype wire

// file: sim/rlc_checker.sv
// Assertions on the lane control register bank ports
`default_nettype none
module rlc_checker #(
   parameter int unsigned TEST_PERIOD_CYC = rlc_pkg::RLC_TEST_PERIOD_CYC
) (
   input wire logic       CLK_SYS_I,
   input wire logic       RST_I,
   input wire logic       SMB_SCL_I,
   input wire logic       SMB_SDA_OE_O,
   input wire logic       RX_TEST_O,
   input wire logic       RECEIVER_FOUND_O,
   input wire logic       TERM_50_O,
   input wire logic [7:0] EQUALIZER_LEVEL_O,
   input wire logic       SHORT_PROT_EN_O,
   input wire logic [2:0] OUTPUT_SWING_LEVEL_O,
   input wire logic [2:0] DEEMPHASIS_LEVEL_O
);
   default clocking cb @(posedge CLK_SYS_I);
   endclocking
   default disable iff (RST_I);
   logic [31:0] gap_q;
   // Saturates, so a stopped sequencer never wraps into a false short gap
   always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
      if (RST_I)
         gap_q <= 32'h0;
      else if (RX_TEST_O)
         gap_q <= 32'h1;
      else if (gap_q != 32'h0 && gap_q != 32'hFFFFFFFF)
         gap_q <= gap_q + 32'h1;
   end
   sequence s_one_pulse;
      RX_TEST_O ##1 !RX_TEST_O;
   endsequence
   property p_pulse;
      RX_TEST_O |-> s_one_pulse;
   endproperty
   a_pulse: assert property (p_pulse) else $error("test pulse too long");
   property p_gap;
      RX_TEST_O && gap_q != 32'h0 |-> gap_q >= TEST_PERIOD_CYC;
   endproperty
   a_gap: assert property (p_gap) else $error("tests too close");
   property p_found_term;
      RECEIVER_FOUND_O |-> TERM_50_O;
   endproperty
   a_found_term: assert property (p_found_term) else $error("found without term");
   property p_test_hiz;
      RX_TEST_O |-> !TERM_50_O && !RECEIVER_FOUND_O;
   endproperty
   a_test_hiz: assert property (p_test_hiz) else $error("test while terminated");
   property p_found_cause;
      $rose(RECEIVER_FOUND_O) |-> $past(RX_TEST_O) || $past(RX_TEST_O, 2);
   endproperty
   a_found_cause: assert property (p_found_cause) else $error("found without test");
   property p_found_clear;
      $fell(RECEIVER_FOUND_O) |-> !SMB_SCL_I;
   endproperty
   a_found_clear: assert property (p_found_clear) else $error("found lost");
   property p_oe_scl;
      $changed(SMB_SDA_OE_O) |-> !SMB_SCL_I;
   endproperty
   a_oe_scl: assert property (p_oe_scl) else $error("data moved, clock high");
   property p_cfg_scl;
      $changed({EQUALIZER_LEVEL_O, SHORT_PROT_EN_O, OUTPUT_SWING_LEVEL_O, DEEMPHASIS_LEVEL_O})
         |-> !SMB_SCL_I;
   endproperty
   a_cfg_scl: assert property (p_cfg_scl) else $error("setting moved off a write");
   property p_rst_vals;
      $fell(RST_I) |-> EQUALIZER_LEVEL_O == 8'h2F && SHORT_PROT_EN_O
         && OUTPUT_SWING_LEVEL_O == 3'h5 && DEEMPHASIS_LEVEL_O == 3'h2;
   endproperty
   a_rst_vals: assert property (p_rst_vals) else $error("bad reset value");
endmodule
bind rlc_lane_regs rlc_checker #(.TEST_PERIOD_CYC(TEST_PERIOD_CYC)) u_chk (
   .CLK_SYS_I, .RST_I, .SMB_SCL_I, .SMB_SDA_OE_O, .RX_TEST_O, .RECEIVER_FOUND_O, .TERM_50_O,
   .EQUALIZER_LEVEL_O, .SHORT_PROT_EN_O, .OUTPUT_SWING_LEVEL_O, .DEEMPHASIS_LEVEL_O
);
`default_nettype wire

// file: sim/rlc_smb_host.sv
// Bus host model driving the clock and data pins of the register bank
`default_nettype none
module rlc_smb_host
   import rlc_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic sda_i,
   output var logic  scl_o,
   output var logic  oe_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      scl_o = 1'b1;
      oe_o  = 1'b0;
   end
   // Eight cycles a phase, well above the three-stage synchroniser delay
   task automatic st(input logic c, input logic o);
      scl_o <= c;
      oe_o  <= o;
      repeat (8) @(posedge clk_i);
   endtask
   // Clock falls first, so data never moves while it is high
   task automatic bitx(input logic v, output logic s);
      st(1'b0, oe_o);
      st(1'b0, ~v);
      st(1'b1, ~v);
      s = sda_i;
   endtask
   task automatic start;
      st(1'b0, oe_o);
      st(1'b0, 1'b0);
      st(1'b1, 1'b0);
      st(1'b1, 1'b1);
   endtask
   task automatic stop;
      st(1'b0, oe_o);
      st(1'b0, 1'b1);
      st(1'b1, 1'b1);
      st(1'b1, 1'b0);
   endtask
   task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] r,
                       output logic a);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bitx(d[i], s);
         r[i] = s;
      end
      bitx(~m, s);
      a = ~s;
   endtask
   task automatic wr(input logic [6:0] id, input logic [7:0] o, input logic [7:0] d,
                     output logic ok);
      logic [7:0] r;
      logic       a1, a2, a3;
      start;
      xfer({id, 1'b0}, 1'b0, r, a1);
      xfer(o, 1'b0, r, a2);
      xfer(d, 1'b0, r, a3);
      stop;
      ok = a1 & a2 & a3;
   endtask
   task automatic rd(input logic [7:0] o, output logic [7:0] d, output logic ok);
      logic [7:0] r;
      logic       a1, a2, a3, a4;
      start;
      xfer({RLC_DEV_ADDR, 1'b0}, 1'b0, r, a1);
      xfer(o, 1'b0, r, a2);
      start;
      xfer({RLC_DEV_ADDR, 1'b1}, 1'b0, r, a3);
      xfer(8'hFF, 1'b0, d, a4);
      stop;
      ok = a1 & a2 & a3;
   endtask
endmodule
`default_nettype wire

// file: sim/rlc_lane_regs_test.sv
// Self-checking bench for the lane control register bank
`default_nettype none
module rlc_lane_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   import rlc_pkg::*;
   localparam int unsigned P = 20;
   logic       clk  = 1'b0;
   logic       rst  = 1'b1;
   logic       raw  = 1'b0;
   logic       raw7 = 1'b0;
   logic       pres = 1'b0;
   logic [1:0] rate = 2'h0;
   logic       scl, oe_h, oe_d, sdo, det, det7, mute, term, tst, fnd, scp, rlow;
   logic [7:0] eq;
   logic [2:0] sw, dm;
   logic [1:0] tha, thd;
   wire logic  sda = ~(oe_d | oe_h);
   int         fail_count = 0;
   int         compares = 0;
   int         pulses = 0;
   int         mfound = 0;
   int         seed = 32'hC1F83E70;
   int         mdl[9] = '{0, 0, 0, 8'h2F, 8'hAD, 2, 0, 0, 0};
   int         msk[9] = '{0, 6, 8'h3C, 8'hFF, 8'hC7, 7, 8'h0F, 0, 6};
   always #2 clk = ~clk;
   always @(posedge clk)
      if (tst === 1'b1) pulses++;
   rlc_smb_host H (.clk_i(clk), .sda_i(sda), .scl_o(scl), .oe_o(oe_h));
   rlc_lane_regs #(.TEST_PERIOD_CYC(P)) DUT (
      .CLK_SYS_I(clk), .RST_I(rst), .SMB_SCL_I(scl), .SMB_SDA_I(sda), .SMB_SDA_O(sdo),
      .SMB_SDA_OE_O(oe_d), .RAW_SIGNAL_DETECT_I(raw), .RAW_SIGNAL_DETECT_L7_I(raw7),
      .RECEIVER_PRESENT_I(pres), .RATE_CLASS_DET_I(rate), .SIGNAL_DETECT_O(det),
      .SIGNAL_DETECT_L7_O(det7), .OUTPUT_MUTE_O(mute), .TERM_50_O(term), .RX_TEST_O(tst),
      .RECEIVER_FOUND_O(fnd), .EQUALIZER_LEVEL_O(eq), .SHORT_PROT_EN_O(scp),
      .RATE_CLASS_LOW_O(rlow), .OUTPUT_SWING_LEVEL_O(sw), .DEEMPHASIS_LEVEL_O(dm),
      .IDLE_ASSERT_TH_O(tha), .IDLE_DEASSERT_TH_O(thd)
   );
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic end_sim;
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic wr(input int i, input int d);
      logic a;
      H.wr(RLC_DEV_ADDR, 8'(i + 8'h37), 8'(d), a);
      chk(8'(a), 8'h01);
      mdl[i] = d;
   endtask
   // Status bits of the de-emphasis register follow the model flag and the driven class
   task automatic rd(input int i);
      logic [7:0] d;
      logic       a;
      int         e;
      H.rd(8'(i + 8'h37), d, a);
      chk(8'(a), 8'h01);
      e = (i < 0 || i > 8) ? 0 : mdl[i];
      if (i == 5) e = (mfound << 7) | (rate << 5) | (e & 8'h1F);
      chk(d, 8'(e));
   endtask
   task automatic outs;
      chk(eq, 8'(mdl[3]));
      chk({scp, rlow, 3'h0, sw}, 8'(mdl[4] & 8'hC7));
      chk(8'(dm), 8'(mdl[5] & 7));
      chk({4'h0, tha, thd}, 8'(mdl[6] & 8'h0F));
      chk(8'(sdo), 8'h00);
   endtask
   initial begin
      int   d, e;
      logic a;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (6) @(posedge clk);
      outs;
      for (int i = -1; i < 10; i++) rd(i);
      for (int k = 0; k < 18; k++) begin
         d = $random(seed) & msk[k % 9];
         if (k % 9 == 4) d = d | 8'h28;
         wr(k % 9, d);
      end
      outs;
      for (int i = 0; i < 9; i++) rd(i);
      H.wr(7'h19, 8'h3A, 8'h00, a);
      chk(8'(a), 8'h00);
      outs;
      wr(2, 0);
      chk(8'(term), 8'h00);
      for (int c = 0; c < 8; c++) begin
         raw <= c[2];
         raw7 <= ~c[2];
         wr(1, (c & 3) << 1);
         wr(8, (c & 3) << 1);
         e = c[1] ? 0 : c[0] ? 1 : c[2];
         d = c[1] ? 0 : c[0] ? 1 : !c[2];
         chk({det, det7}, 8'(e * 2 + d));
         chk(8'(mute), 8'(!e));
      end
      for (int m = 0; m < 2; m++) begin
         wr(2, 8'h20 | (m << 4));
         chk(8'(mute), 8'(m));
      end
      wr(2, 8'h0C);
      pulses = 0;
      repeat (3 * P) @(posedge clk);
      chk(8'(term), 8'h01);
      chk(8'(pulses), 8'h00);
      wr(2, 4);
      repeat (55 * P) @(posedge clk);
      chk(8'(pulses), 8'h32);
      chk({fnd, term}, 8'h00);
      pulses = 0;
      wr(2, 8);
      repeat (60 * P) @(posedge clk);
      chk(8'(pulses > 50), 8'h01);
      pres <= 1'b1;
      repeat (2 * P + 8) @(posedge clk);
      mfound = 1;
      chk({fnd, term}, 8'h03);
      d = pulses;
      repeat (3 * P) @(posedge clk);
      chk(8'(pulses - d), 8'h00);
      rd(5);
      for (int r = 0; r < 4; r++) begin
         if (r != 2) begin
            rate <= 2'(r);
            repeat (4) @(posedge clk);
            rd(5);
         end
      end
      wr(2, 0);
      mfound = 0;
      chk({fnd, term}, 8'h00);
      end_sim;
   end
   // Expected run is near 55438 cycles
   initial begin
      repeat (95000) @(posedge clk);
      fail_count++;
      $display("MISMATCH %0t watchdog", $time);
      end_sim;
   end
endmodule
`default_nettype wire
